//--- hw/bch_params.svh
// Constants of the bias controller hardware configuration block.
// Assumes a serial front end that hands over decoded command codes.
// How it works
// - Twelve-bit low current limit, reset zero
// - Equation bit picks one sixteenth or quarter
// - Limiter code n clamps difference to 2^n-1, code 0 no clamp
// - Flow enable routes queue flow to alert while stream mode is active
// - Monitor enable copies each conversion result
// - Gain codes give 2, 10 or 25
// - Mode 00 converts all on register write
// - Mode 01 converts all per pin pulse
// - Mode 11 converts next channel per pulse
// - ADC reference external or internal, cap hint
// - DAC reference external or internal
// - Initial average built from sixteen samples
// - Difference clamped before fraction is added
`ifndef BCH_PARAMS_SVH
`define BCH_PARAMS_SVH
`define BCH_CMD_ILO_WR   8'h26
`define BCH_CMD_ILO_RD   8'ha6
`define BCH_CMD_HCFG_WR  8'h30
`define BCH_CMD_HCFG_RD  8'hb0
`define BCH_CMD_CONV_WR  8'h62
`define BCH_ILO_RST      12'h000
`define BCH_HCFG_RST     16'h0000
`define BCH_HCFG_RD_MASK 16'h0fff
`define BCH_INIT_SAMPLES 5'h10
`define BCH_PTR_RST      3'h7
`endif

//--- hw/bch_pkg.sv
// Types of the bias controller hardware configuration block.
// Assumes bch_params.svh supplies the numeric constants.
package bch_pkg;
    typedef struct packed {
        logic       ch1_avg_equation_sel;
        logic [2:0] ch1_diff_limiter;
        logic       alert_fifo_flow_enable;
        logic       conv_result_to_queue_enable;
        logic [1:0] ch2_sense_gain;
        logic [1:0] ch1_sense_gain;
        logic [1:0] conversion_clock_mode;
        logic [1:0] adc_reference_select;
        logic [1:0] dac_reference_select;
    } bch_hcfg_s;

    typedef enum logic [1:0] {
        BCH_GAIN_2  = 2'h0,
        BCH_GAIN_10 = 2'h1,
        BCH_GAIN_25 = 2'h2
    } bch_gain_e;

    typedef enum logic [1:0] {
        BCH_CKM_WRITE    = 2'h0,
        BCH_CKM_PIN_SEQ  = 2'h1,
        BCH_CKM_RESERVED = 2'h2,
        BCH_CKM_PIN_STEP = 2'h3
    } bch_ckmode_e;

    typedef enum logic [1:0] {
        BCH_AVG_INIT  = 2'h1,
        BCH_AVG_TRACK = 2'h2
    } bch_avg_e;

    typedef struct packed {
        logic adc_internal;
        logic adc_decouple_cap;
        logic dac_internal;
        logic dac_decouple_cap;
    } bch_ref_s;
endpackage

//--- hw/bch_hw_config.sv
// Low current threshold and hardware configuration registers with their decodes.
// Assumes all inputs except the conversion start pin share core_clk.
`include "bch_params.svh"
`timescale 1ns/10ps
`default_nettype none
module bch_hw_config (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Register access from the serial front end
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_cmd,
    input  wire logic [15:0]       reg_wdata,
    output logic [15:0]            reg_rdata,
    output logic                   reg_rd_valid,
    // Conversion control
    input  wire logic              conversion_start_pin,
    input  wire logic [7:0]        adc_chan_enable,
    output logic                   conv_seq_start,
    output logic                   conv_single_start,
    output logic [2:0]             conv_single_chan,
    // Conversion results and queue copy
    input  wire logic              conv_done,
    input  wire logic [15:0]       conv_data,
    output logic                   queue_wr,
    output logic [15:0]            queue_wr_data,
    // Alert output flow monitor
    input  wire logic              stream_mode_active,
    input  wire logic              queue_flow_level,
    output logic                   alert_flow_drive,
    output logic                   alert_flow_level,
    // Channel 1 temperature averaging
    input  wire logic              ch1_sample_valid,
    input  wire logic [11:0]       ch1_sample,
    output logic [11:0]            ch1_average,
    output logic                   ch1_average_ready,
    // Analog settings
    output bch_pkg::bch_gain_e     ch1_gain,
    output bch_pkg::bch_gain_e     ch2_gain,
    output bch_pkg::bch_ref_s      ref_sel,
    output logic [11:0]            low_current_limit_value
);
    // Register state
    logic [11:0]        ilo_ff, nxt_ilo;
    bch_pkg::bch_hcfg_s hcfg_ff, nxt_hcfg;
    logic [15:0]        rdata_ff, nxt_rdata;
    logic               rdv_ff, nxt_rdv;

    always_comb begin
        nxt_ilo   = ilo_ff;
        nxt_hcfg  = hcfg_ff;
        nxt_rdv   = reg_rd_en;
        nxt_rdata = 16'h0000;
        if (reg_wr_en && reg_cmd == `BCH_CMD_ILO_WR) begin
            nxt_ilo = reg_wdata[11:0];
        end
        if (reg_wr_en && reg_cmd == `BCH_CMD_HCFG_WR) begin
            nxt_hcfg = bch_pkg::bch_hcfg_s'(reg_wdata);
        end
        if (reg_rd_en && reg_cmd == `BCH_CMD_ILO_RD) begin
            nxt_rdata = {4'h0, ilo_ff};
        end
        if (reg_rd_en && reg_cmd == `BCH_CMD_HCFG_RD) begin
            // Write-only averaging fields read back as zero
            nxt_rdata = 16'(hcfg_ff) & `BCH_HCFG_RD_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ilo_ff   <= `BCH_ILO_RST;
            hcfg_ff  <= bch_pkg::bch_hcfg_s'(`BCH_HCFG_RST);
            rdata_ff <= 16'h0000;
            rdv_ff   <= 1'b0;
        end else begin
            ilo_ff   <= nxt_ilo;
            hcfg_ff  <= nxt_hcfg;
            rdata_ff <= nxt_rdata;
            rdv_ff   <= nxt_rdv;
        end
    end

    assign reg_rdata               = rdata_ff;
    assign reg_rd_valid            = rdv_ff;
    assign low_current_limit_value = ilo_ff;

    // Static decodes; the high gain bit alone selects 25
    function automatic bch_pkg::bch_gain_e gain_of(input logic [1:0] code);
        gain_of = code[1] ? bch_pkg::BCH_GAIN_25
                : (code[0] ? bch_pkg::BCH_GAIN_10 : bch_pkg::BCH_GAIN_2);
    endfunction

    assign ch1_gain = gain_of(hcfg_ff.ch1_sense_gain);
    assign ch2_gain = gain_of(hcfg_ff.ch2_sense_gain);
    assign ref_sel.adc_internal     = hcfg_ff.adc_reference_select[1];
    assign ref_sel.adc_decouple_cap = &hcfg_ff.adc_reference_select;
    assign ref_sel.dac_internal     = hcfg_ff.dac_reference_select[1];
    assign ref_sel.dac_decouple_cap = &hcfg_ff.dac_reference_select;

    // Pin synchroniser and low pulse detect
    logic cs_meta_ff, cs_sync_ff, cs_prev_ff;
    logic cs_fall;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end else begin
            cs_meta_ff <= conversion_start_pin;
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
        end
    end

    assign cs_fall = cs_prev_ff & ~cs_sync_ff;

    // Conversion triggers
    logic       seq_ff, nxt_seq;
    logic       one_ff, nxt_one;
    logic [2:0] ptr_ff, nxt_ptr;
    logic       any_en;
    logic       conv_wr;
    logic [2:0] next_chan;

    // Next enabled channel after the pointer, wrapping round
    function automatic logic [2:0] next_enabled(input logic [2:0] p, input logic [7:0] en);
        logic [2:0] c;
        next_enabled = p;
        for (int i = 7; i >= 1; i--) begin
            c = 3'(p + 3'(i));
            if (en[c]) begin
                next_enabled = c;
            end
        end
    endfunction

    assign any_en    = |adc_chan_enable;
    assign conv_wr   = reg_wr_en && reg_cmd == `BCH_CMD_CONV_WR;
    assign next_chan = next_enabled(conv_wr ? `BCH_PTR_RST : ptr_ff, adc_chan_enable);

    always_comb begin
        nxt_seq = 1'b0;
        nxt_one = 1'b0;
        // A fresh channel setup restarts the stepping at the lowest channel
        nxt_ptr = conv_wr ? `BCH_PTR_RST : ptr_ff;
        // Reserved mode 10 starts nothing
        unique case (bch_pkg::bch_ckmode_e'(hcfg_ff.conversion_clock_mode))
            bch_pkg::BCH_CKM_WRITE: begin
                nxt_seq = conv_wr && any_en;
            end
            bch_pkg::BCH_CKM_PIN_SEQ: begin
                nxt_seq = cs_fall && any_en;
            end
            bch_pkg::BCH_CKM_RESERVED: begin
                nxt_seq = 1'b0;
            end
            bch_pkg::BCH_CKM_PIN_STEP: begin
                if (cs_fall && any_en) begin
                    nxt_one = 1'b1;
                    nxt_ptr = next_chan;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq_ff <= 1'b0;
            one_ff <= 1'b0;
            ptr_ff <= `BCH_PTR_RST;
        end else begin
            seq_ff <= nxt_seq;
            one_ff <= nxt_one;
            ptr_ff <= nxt_ptr;
        end
    end

    assign conv_seq_start    = seq_ff;
    assign conv_single_start = one_ff;
    assign conv_single_chan  = ptr_ff;

    // Result copy and alert flow monitor
    logic        qw_ff, nxt_qw;
    logic [15:0] qd_ff, nxt_qd;
    logic        afd_ff, nxt_afd;
    logic        afl_ff, nxt_afl;

    always_comb begin
        // Average copies are not seen here; exclusivity is left to software
        nxt_qw  = conv_done && hcfg_ff.conv_result_to_queue_enable;
        nxt_qd  = nxt_qw ? conv_data : qd_ff;
        nxt_afd = hcfg_ff.alert_fifo_flow_enable && stream_mode_active;
        nxt_afl = nxt_afd && queue_flow_level;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            qw_ff  <= 1'b0;
            qd_ff  <= 16'h0000;
            afd_ff <= 1'b0;
            afl_ff <= 1'b0;
        end else begin
            qw_ff  <= nxt_qw;
            qd_ff  <= nxt_qd;
            afd_ff <= nxt_afd;
            afl_ff <= nxt_afl;
        end
    end

    assign queue_wr         = qw_ff;
    assign queue_wr_data    = qd_ff;
    assign alert_flow_drive = afd_ff;
    assign alert_flow_level = afl_ff;

    // Channel 1 averaging, samples are signed eighths of a degree
    bch_pkg::bch_avg_e  st_ff, nxt_st;
    logic [4:0]         cnt_ff, nxt_cnt;
    logic signed [15:0] sum_ff, nxt_sum;
    logic signed [11:0] avg_ff, nxt_avg;
    logic signed [12:0] diff, lim, clamped, step;

    always_comb begin
        diff = 13'(signed'(ch1_sample)) - 13'(avg_ff);
        lim  = 13'((13'h1 << hcfg_ff.ch1_diff_limiter) - 13'h1);
        clamped = diff;
        if (hcfg_ff.ch1_diff_limiter != 3'h0) begin
            if (diff > lim) begin
                clamped = lim;
            end else if (diff < -lim) begin
                clamped = -lim;
            end
        end
        step = hcfg_ff.ch1_avg_equation_sel ? (clamped >>> 2) : (clamped >>> 4);
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sum = sum_ff;
        nxt_avg = avg_ff;
        unique case (st_ff)
            bch_pkg::BCH_AVG_INIT: begin
                if (ch1_sample_valid) begin
                    nxt_sum = sum_ff + 16'(signed'(ch1_sample));
                    nxt_cnt = cnt_ff + 5'h1;
                    if (nxt_cnt == `BCH_INIT_SAMPLES) begin
                        nxt_avg = 12'(nxt_sum >>> 4);
                        nxt_st  = bch_pkg::BCH_AVG_TRACK;
                    end
                end
            end
            bch_pkg::BCH_AVG_TRACK: begin
                if (ch1_sample_valid) begin
                    nxt_avg = 12'(13'(avg_ff) + step);
                end
            end
            default: begin
                nxt_st = bch_pkg::BCH_AVG_INIT;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff  <= bch_pkg::BCH_AVG_INIT;
            cnt_ff <= 5'h00;
            sum_ff <= 16'sh0000;
            avg_ff <= 12'sh000;
        end else begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
            sum_ff <= nxt_sum;
            avg_ff <= nxt_avg;
        end
    end

    assign ch1_average       = avg_ff;
    assign ch1_average_ready = (st_ff == bch_pkg::BCH_AVG_TRACK);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ilo_write: assert property (
        reg_wr_en && reg_cmd == `BCH_CMD_ILO_WR |=> ilo_ff == $past(reg_wdata[11:0]))
        else $error("low current limit not stored");
    a_eq_quarter: assert property (
        st_ff == bch_pkg::BCH_AVG_TRACK && ch1_sample_valid && hcfg_ff.ch1_avg_equation_sel
        |=> 13'(avg_ff) - 13'($past(avg_ff)) == ($past(clamped) >>> 2))
        else $error("quarter update wrong");
    a_limit_mag: assert property (
        hcfg_ff.ch1_diff_limiter == 3'h7 |-> clamped <= 13'sd127 && clamped >= -13'sd127)
        else $error("limiter exceeded");
    a_flow_alert: assert property (
        !hcfg_ff.alert_fifo_flow_enable |=> !alert_flow_drive ##0 !alert_flow_level)
        else $error("alert flow without enable");
    a_queue_copy: assert property (
        conv_done |=> queue_wr == $past(hcfg_ff.conv_result_to_queue_enable))
        else $error("result copy wrong");
    a_gain_code: assert property (
        hcfg_ff.ch1_sense_gain[1] |-> ch1_gain == bch_pkg::BCH_GAIN_25)
        else $error("gain 25 not chosen");
    a_write_seq: assert property (
        hcfg_ff.conversion_clock_mode == 2'h0 && conv_wr && any_en |=> conv_seq_start)
        else $error("write did not start sequence");
    a_pin_seq: assert property (
        hcfg_ff.conversion_clock_mode == 2'h1 && $fell(cs_sync_ff) && any_en |=> conv_seq_start)
        else $error("pin did not start sequence");
    a_step_chan: assert property (
        conv_single_start |-> (($past(adc_chan_enable) >> conv_single_chan) & 8'h01) != 8'h00)
        else $error("stepped to disabled channel");
    a_init_count: assert property (
        st_ff == bch_pkg::BCH_AVG_INIT |-> cnt_ff < `BCH_INIT_SAMPLES)
        else $error("initial count overran");
    c_track: cover property (st_ff == bch_pkg::BCH_AVG_INIT ##1 st_ff == bch_pkg::BCH_AVG_TRACK);
    c_step: cover property (conv_single_start ##[1:20] conv_single_start);
    c_copy: cover property (queue_wr);
    c_clamp: cover property (ch1_sample_valid && clamped != diff);
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the hardware configuration block.
// Assumes the design samples its inputs on core_clk rising edges.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic               reg_wr_en = 1'b0;
    logic               reg_rd_en = 1'b0;
    logic [7:0]         reg_cmd = 8'h00;
    logic [15:0]        reg_wdata = 16'h0000;
    logic [15:0]        reg_rdata;
    logic               reg_rd_valid;
    logic               pin = 1'b1;
    logic [7:0]         chan_en = 8'h05;
    logic               seq_start;
    logic               single_start;
    logic [2:0]         single_chan;
    logic               conv_done = 1'b0;
    logic [15:0]        conv_data = 16'h0000;
    logic               queue_wr;
    logic [15:0]        queue_data;
    logic               stream = 1'b0;
    logic               flow = 1'b0;
    logic               alert_drive;
    logic               alert_level;
    logic               smp_valid = 1'b0;
    logic [11:0]        smp = 12'h000;
    logic [11:0]        avg;
    logic               avg_ready;
    bch_pkg::bch_gain_e ch1_gain;
    bch_pkg::bch_gain_e ch2_gain;
    bch_pkg::bch_ref_s  ref_sel;
    logic [11:0]        ilo;
    int                 failures = 0;
    int                 comparisons = 0;
    logic [1:0]         c;

    bch_hw_config i_dut (
        .core_clk(core_clk), .rst(rst),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_cmd(reg_cmd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .conversion_start_pin(pin), .adc_chan_enable(chan_en),
        .conv_seq_start(seq_start), .conv_single_start(single_start),
        .conv_single_chan(single_chan), .conv_done(conv_done), .conv_data(conv_data),
        .queue_wr(queue_wr), .queue_wr_data(queue_data),
        .stream_mode_active(stream), .queue_flow_level(flow),
        .alert_flow_drive(alert_drive), .alert_flow_level(alert_level),
        .ch1_sample_valid(smp_valid), .ch1_sample(smp), .ch1_average(avg),
        .ch1_average_ready(avg_ready), .ch1_gain(ch1_gain), .ch2_gain(ch2_gain),
        .ref_sel(ref_sel), .low_current_limit_value(ilo)
    );

    always #20 core_clk = ~core_clk;

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_cmd   <= cmd;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_cmd   <= cmd;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1;
        chk({15'h0000, reg_rd_valid}, 16'h0001);
        chk(reg_rdata, exp);
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = seq_start;
            1: pick = single_start;
            default: pick = queue_wr;
        endcase
    endfunction

    // Looks from the current cycle on; a missed pulse ends the run
    task automatic scan(input int sel, input int bound, input logic want);
        int n;
        for (n = 0; n < bound; n++) begin
            #1;
            if (pick(sel) === 1'b1) begin
                break;
            end
            @(posedge core_clk);
        end
        chk({15'h0000, n < bound}, {15'h0000, want});
        if (want && n == bound) begin
            tally_and_finish();
        end
    endtask

    // Two cycles low so the synchroniser cannot miss it
    task automatic pin_pulse();
        @(posedge core_clk);
        pin <= 1'b0;
        repeat (2) @(posedge core_clk);
        pin <= 1'b1;
    endtask

    task automatic conv(input logic [15:0] data);
        @(posedge core_clk);
        conv_done <= 1'b1;
        conv_data <= data;
        @(posedge core_clk);
        conv_done <= 1'b0;
    endtask

    task automatic sample(input logic [11:0] v);
        @(posedge core_clk);
        smp_valid <= 1'b1;
        smp       <= v;
        @(posedge core_clk);
        smp_valid <= 1'b0;
        tick(1);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'ha6, 16'h0000);
        rd(8'hb0, 16'h0000);
        chk({4'h0, ilo}, 16'h0000);
        wr(8'h26, 16'hffff);
        rd(8'ha6, 16'h0fff);
        chk({4'h0, ilo}, 16'h0fff);
        wr(8'h30, 16'hffff);
        rd(8'hb0, 16'h0fff);
        rd(8'h55, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(8'h30, {6'h00, c, c, 2'h0, c, c});
            chk({14'h0000, ch1_gain}, {14'h0000, c[1] ? 2'h2 : c});
            chk({14'h0000, ch2_gain}, {14'h0000, c[1] ? 2'h2 : c});
            chk({12'h000, ref_sel}, {12'h000, c[1], c == 2'h3, c[1], c == 2'h3});
        end
        wr(8'h30, 16'h0000);
        wr(8'h62, 16'h0000);
        scan(0, 3, 1'b1);
        tick(1);
        chk({15'h0000, seq_start}, 16'h0000);
        wr(8'h30, 16'h0010);
        pin_pulse();
        scan(0, 6, 1'b1);
        @(posedge core_clk);
        chan_en <= 8'h00;
        pin_pulse();
        scan(0, 6, 1'b0);
        @(posedge core_clk);
        chan_en <= 8'h05;
        wr(8'h30, 16'h0000);
        pin_pulse();
        scan(0, 6, 1'b0);
        wr(8'h30, 16'h0030);
        for (int k = 0; k < 3; k++) begin
            pin_pulse();
            scan(1, 6, 1'b1);
            chk({13'h0000, single_chan}, (k == 1) ? 16'h0002 : 16'h0000);
        end
        wr(8'h30, 16'h0400);
        conv(16'ha5c3);
        scan(2, 1, 1'b1);
        chk(queue_data, 16'ha5c3);
        wr(8'h30, 16'h0000);
        conv(16'h3c5a);
        scan(2, 3, 1'b0);
        wr(8'h30, 16'h0800);
        @(posedge core_clk);
        stream <= 1'b1;
        flow   <= 1'b1;
        tick(3);
        chk({14'h0000, alert_drive, alert_level}, 16'h0003);
        wr(8'h30, 16'h0000);
        tick(3);
        chk({14'h0000, alert_drive, alert_level}, 16'h0000);
        repeat (15) sample(12'h064);
        chk({15'h0000, avg_ready}, 16'h0000);
        sample(12'h064);
        chk({3'h0, avg_ready, avg}, 16'h1064);
        sample(12'h104);
        chk({4'h0, avg}, 16'h006e);
        wr(8'h30, 16'hb000);
        sample(12'h0d2);
        chk({4'h0, avg}, 16'h006f);
        sample(12'h000);
        chk({4'h0, avg}, 16'h006d);
        wr(8'h30, 16'hf000);
        sample(12'h7ff);
        chk({4'h0, avg}, 16'h008c);
        tally_and_finish();
    end
endmodule
`default_nettype wire
